//--- core/tdm_pkg.sv
package tdm_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CFG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ERR_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ERR_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ERR_QUEUE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_BUF_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FRAME_STRIDE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FRAME_LENGTH = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FRAMES_PER_BUF = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_TX_TALLY = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_RX_TALLY = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_DMA_CTRL = 8'h30;

    // error control / count fields
    localparam int CTRL_POP_BIT = 0;
    localparam int CTRL_FLUSH_BIT = 1;
    localparam int CTRL_OVCLR_BIT = 8;
    localparam int CNT_OVF_BIT = 8;
    localparam int CNT_W = 5;
    localparam int QUEUE_DEPTH = 16;

    // error entry layout
    localparam int CODE_W = 8;
    localparam int INFO_W = 24;
    localparam int CFG_ID_W = 8;

    // buffer fields
    localparam int STRIDE_W = 12;
    localparam int CHANNEL_FRAMES_PER_BUFFER_W = 8;
    localparam int TALLY_W = 24;
    localparam logic [DATA_W-1:0] BASE_ALIGN_MASK = 32'hffff_fffc;
    localparam logic [STRIDE_W-1:0] FIELD_ALIGN_MASK = 12'hffc;
    localparam logic [DATA_W-1:0] BUF_BASE_RESET = 32'h0000_0000;

    // active configuration encoding
    localparam logic [1:0] CFG_NONE = 2'b00;
    localparam logic [1:0] CFG_A = 2'b01;
    localparam logic [1:0] CFG_B = 2'b10;

    // interrupt status bits
    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;
    localparam int IRQ_WRAP_BIT = 2;
    localparam int IRQ_W = 3;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [1:0] {CAT_PLAIN, CAT_FRAME, CAT_CONFIG} err_cat_t;
    typedef enum logic {DMA_IDLE, DMA_REQ} dma_state_t;
endpackage

//--- core/err_queue_if.sv
`timescale 1ns/10ps
interface err_queue_if #(parameter int WIDTH = 32, parameter int CW = 5);
    logic push;
    logic [WIDTH-1:0] push_data;
    logic pop;
    logic flush;
    logic [WIDTH-1:0] head;
    logic [CW-1:0] count;
    logic full;

    modport store (input push, input push_data, input pop, input flush,
        output head, output count, output full);
    modport user (output push, output push_data, output pop, output flush,
        input head, input count, input full);
endinterface

//--- core/err_queue.sv
`timescale 1ns/10ps
module err_queue
    import tdm_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int WIDTH = DATA_W,
    parameter int CW = CNT_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // queue port
    err_queue_if.store q
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] count_q;

    wire empty = (count_q == '0);
    wire do_push = q.push && !q.full;
    wire do_pop = q.pop && !empty;
    wire [PW-1:0] wr_at = q.flush ? '0 : wr_q;

    assign q.full = (count_q == DEPTH_C);
    assign q.count = count_q;
    assign q.head = empty ? '0 : mem_q[rd_q];

    always_ff @(posedge aclk) begin
        if (do_push || (q.flush && q.push)) begin
            mem_q[wr_at] <= q.push_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else if (q.flush) begin
            // new entry survives a flush in the same cycle
            wr_q <= q.push ? PW'(1) : '0;
            rd_q <= '0;
            count_q <= q.push ? CW'(1) : '0;
        end else begin
            if (do_push) begin
                wr_q <= PW'(wr_q + 1'b1);
            end
            if (do_pop) begin
                rd_q <= PW'(rd_q + 1'b1);
            end
            if (do_push && !do_pop) begin
                count_q <= CW'(count_q + 1'b1);
            end else if (do_pop && !do_push) begin
                count_q <= CW'(count_q - 1'b1);
            end
        end
    end
endmodule

//--- core/tdm_channel_status.sv
// Behaviour
// [RL1] config status reads 00 none, 01 config A, 10 config B active.
// [RL2] writing 1 to control bit 8 clears overflow flag; 0 does nothing.
// [RL3] writing 1 to control bit 1 discards all queue entries.
// [RL4] writing 1 to control bit 0 pops the oldest queue entry.
// [RL5] control command bits always read back as zero.
// [RL6] overflow flag, count bit 8, sets when an error entry is lost.
// [RL7] overflow stays set until the overflow-clear command; pops leave it.
// [RL8] count bits 4..0 give the number of unread queue entries.
// [RL9] queue register returns head entry: code 31..24, information 23..0.
// [RL10] category 0 entry carries only the code; information bits zero.
// [RL11] category 1 entry carries captured 24-bit frame tally in 23..0.
// [RL12] category 2 entry: live config id 15..8, buffer config id 7..0.
// [RL13] buffer base address has its two low bits forced to zero.
// [RL14] frame k starts at base plus k times stride, stride word aligned.
// [RL15] transmit moves frame length bytes, word aligned; receive ignores it.
// [RL16] frames per buffer is 1..255; position wraps to base after that.
// [RL17] read-only 24-bit free running tx and rx frame tallies.
// [RL18] popping an empty queue changes nothing.
`timescale 1ns/10ps
module tdm_channel_status
    import tdm_pkg::*;
#(
    parameter bit IS_TX = 1'b1,
    parameter int DEPTH = QUEUE_DEPTH
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // configuration state from the timeslot engine
    input wire logic cfg_a_active,
    input wire logic cfg_b_active,
    // frame boundaries
    input wire logic tx_frame_tick,
    input wire logic rx_frame_tick,
    // error detection
    input wire logic err_valid,
    input wire err_cat_t err_category,
    input wire logic [CODE_W-1:0] fault_code,
    input wire logic err_on_rx,
    input wire logic [CFG_ID_W-1:0] live_config_id,
    input wire logic [CFG_ID_W-1:0] buffer_config_id,
    // frame transfer requests toward memory
    input wire logic frame_start,
    input wire logic [STRIDE_W-1:0] rx_frame_bytes,
    output logic dma_req_valid,
    input wire logic dma_req_ready,
    output logic [DATA_W-1:0] dma_req_addr,
    output logic [STRIDE_W-1:0] dma_req_bytes,
    output logic [CHANNEL_FRAMES_PER_BUFFER_W-1:0] dma_req_frame,
    // interrupt
    output logic irq
);
    // bus handshake state
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [STRB_W-1:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    // software registers
    logic [DATA_W-1:0] base_q;
    logic [STRIDE_W-1:0] stride_q;
    logic [STRIDE_W-1:0] length_q;
    logic [CHANNEL_FRAMES_PER_BUFFER_W-1:0] fpb_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_stat_d;
    logic dma_en_q;

    // block state
    logic ovf_q;
    logic [TALLY_W-1:0] tx_tally_q;
    logic [TALLY_W-1:0] rx_tally_q;
    logic [CHANNEL_FRAMES_PER_BUFFER_W-1:0] frame_idx_q;
    logic [DATA_W-1:0] frame_ofs_q;
    dma_state_t dma_state_q;

    err_queue_if #(.WIDTH(DATA_W), .CW(CNT_W)) eq ();

    err_queue #(.DEPTH(DEPTH), .WIDTH(DATA_W), .CW(CNT_W)) u_queue (
        .aclk(aclk),
        .aresetn(aresetn),
        .q(eq)
    );

    // byte-lane merge for register writes
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] val, input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // write channel
    wire do_write = aw_held_q && w_held_q && !bvalid_q;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [DATA_W-1:0] wmerge_base = merge(base_q, wdata_q, wstrb_q);
    wire [DATA_W-1:0] wmerge_stride = merge({{(DATA_W-STRIDE_W){1'b0}}, stride_q},
        wdata_q, wstrb_q);
    wire [DATA_W-1:0] wmerge_length = merge({{(DATA_W-STRIDE_W){1'b0}}, length_q},
        wdata_q, wstrb_q);
    wire [DATA_W-1:0] wmerge_fpb = merge({{(DATA_W-CHANNEL_FRAMES_PER_BUFFER_W){1'b0}}, fpb_q},
        wdata_q, wstrb_q);
    wire [DATA_W-1:0] wmerge_mask = merge({{(DATA_W-IRQ_W){1'b0}}, irq_mask_q},
        wdata_q, wstrb_q);
    wire [DATA_W-1:0] wmerge_dma = merge({{(DATA_W-1){1'b0}}, dma_en_q},
        wdata_q, wstrb_q);
    wire [DATA_W-1:0] wcmd = merge('0, wdata_q, wstrb_q);

    wire wr_ctrl = do_write && (awaddr_q == OFS_ERR_CTRL);
    wire wr_base = do_write && (awaddr_q == OFS_BUF_BASE);
    wire wr_stride = do_write && (awaddr_q == OFS_FRAME_STRIDE);
    wire wr_length = do_write && (awaddr_q == OFS_FRAME_LENGTH);
    wire wr_fpb = do_write && (awaddr_q == OFS_FRAMES_PER_BUF);
    wire wr_mask = do_write && (awaddr_q == OFS_IRQ_MASK);
    wire wr_dma = do_write && (awaddr_q == OFS_DMA_CTRL);
    wire wr_ro = (awaddr_q == OFS_CFG_STATUS) || (awaddr_q == OFS_ERR_COUNT) ||
        (awaddr_q == OFS_ERR_QUEUE) || (awaddr_q == OFS_TX_TALLY) ||
        (awaddr_q == OFS_RX_TALLY) || (awaddr_q == OFS_IRQ_STATUS);
    wire wr_hit = wr_ctrl || wr_base || wr_stride || wr_length || wr_fpb ||
        wr_mask || wr_dma || (do_write && wr_ro);

    wire ovf_clear_cmd = wr_ctrl && wcmd[CTRL_OVCLR_BIT]; // [RL2]
    wire queue_flush_cmd = wr_ctrl && wcmd[CTRL_FLUSH_BIT]; // [RL3]
    wire queue_drop_head_cmd = wr_ctrl && wcmd[CTRL_POP_BIT]; // [RL4]

    // configuration status encoding
    wire [1:0] config_select_state = (cfg_a_active && !cfg_b_active) ? CFG_A :
        (cfg_b_active && !cfg_a_active) ? CFG_B : CFG_NONE; // [RL1]

    // error entry formatting
    wire [TALLY_W-1:0] captured_frame_number = err_on_rx ? rx_tally_q : tx_tally_q; // [RL11]
    wire [DATA_W-1:0] entry_plain = {fault_code, {INFO_W{1'b0}}}; // [RL10]
    wire [DATA_W-1:0] entry_frame = {fault_code, captured_frame_number}; // [RL11]
    wire [DATA_W-1:0] entry_config = {fault_code, {CFG_ID_W{1'b0}},
        live_config_id, buffer_config_id}; // [RL12]
    wire [DATA_W-1:0] entry = (err_category == CAT_FRAME) ? entry_frame :
        (err_category == CAT_CONFIG) ? entry_config : entry_plain;
    wire entry_lost = err_valid && eq.full && !queue_flush_cmd; // [RL6]

    assign eq.push = err_valid;
    assign eq.push_data = entry;
    assign eq.pop = queue_drop_head_cmd; // [RL4] [RL18]
    assign eq.flush = queue_flush_cmd; // [RL3]

    // buffer geometry, word aligned
    wire [DATA_W-1:0] buffer_base = base_q & BASE_ALIGN_MASK; // [RL13]
    wire [STRIDE_W-1:0] frame_stride = stride_q & FIELD_ALIGN_MASK; // [RL14]
    wire [STRIDE_W-1:0] frame_length = length_q & FIELD_ALIGN_MASK; // [RL15]
    wire frame_done = (dma_state_q == DMA_REQ) && dma_req_ready;
    wire last_frame = (CHANNEL_FRAMES_PER_BUFFER_W'(frame_idx_q + 1'b1) >= fpb_q); // [RL16]

    // read decode
    wire [DATA_W-1:0] cnt_word = {{(DATA_W-CNT_OVF_BIT-1){1'b0}}, ovf_q,
        {(CNT_OVF_BIT-CNT_W){1'b0}}, eq.count}; // [RL8]
    wire rd_irq_stat = (s_axi_araddr == OFS_IRQ_STATUS);
    // map is contiguous words from offset zero up to the dma control word
    wire rd_hit = (s_axi_araddr <= OFS_DMA_CTRL) && (s_axi_araddr[1:0] == '0);
    wire [DATA_W-1:0] rd_word =
        (s_axi_araddr == OFS_CFG_STATUS) ? {{(DATA_W-2){1'b0}}, config_select_state} :
        (s_axi_araddr == OFS_ERR_COUNT) ? cnt_word :
        (s_axi_araddr == OFS_ERR_QUEUE) ? eq.head : // [RL9]
        (s_axi_araddr == OFS_BUF_BASE) ? buffer_base :
        (s_axi_araddr == OFS_FRAME_STRIDE) ? {{(DATA_W-STRIDE_W){1'b0}}, frame_stride} :
        (s_axi_araddr == OFS_FRAME_LENGTH) ? {{(DATA_W-STRIDE_W){1'b0}}, frame_length} :
        (s_axi_araddr == OFS_FRAMES_PER_BUF) ? {{(DATA_W-CHANNEL_FRAMES_PER_BUFFER_W){1'b0}}, fpb_q} :
        (s_axi_araddr == OFS_TX_TALLY) ? {{(DATA_W-TALLY_W){1'b0}}, tx_tally_q} :
        (s_axi_araddr == OFS_RX_TALLY) ? {{(DATA_W-TALLY_W){1'b0}}, rx_tally_q} :
        rd_irq_stat ? {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q} :
        (s_axi_araddr == OFS_IRQ_MASK) ? {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q} :
        (s_axi_araddr == OFS_DMA_CTRL) ? {{(DATA_W-1){1'b0}}, dma_en_q} :
        '0; // [RL5]

    // interrupt events
    wire [IRQ_W-1:0] irq_evt = {frame_done && last_frame, entry_lost,
        err_valid && !entry_lost};

    // bus outputs
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // transfer request outputs
    assign dma_req_valid = (dma_state_q == DMA_REQ);
    assign dma_req_addr = buffer_base + frame_ofs_q; // [RL14]
    assign dma_req_bytes = IS_TX ? frame_length : rx_frame_bytes; // [RL15]
    assign dma_req_frame = frame_idx_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_q <= BUF_BASE_RESET;
            stride_q <= '0;
            length_q <= '0;
            fpb_q <= '0;
            irq_mask_q <= '0;
            dma_en_q <= 1'b0;
        end else begin
            if (wr_base) begin
                base_q <= wmerge_base & BASE_ALIGN_MASK; // [RL13]
            end
            if (wr_stride) begin
                stride_q <= wmerge_stride[STRIDE_W-1:0] & FIELD_ALIGN_MASK; // [RL14]
            end
            if (wr_length) begin
                length_q <= wmerge_length[STRIDE_W-1:0] & FIELD_ALIGN_MASK; // [RL15]
            end
            if (wr_fpb) begin
                fpb_q <= wmerge_fpb[CHANNEL_FRAMES_PER_BUFFER_W-1:0];
            end
            if (wr_mask) begin
                irq_mask_q <= wmerge_mask[IRQ_W-1:0];
            end
            if (wr_dma) begin
                dma_en_q <= wmerge_dma[0];
            end
        end
    end

    // overflow flag, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_q <= 1'b0;
        end else if (entry_lost) begin
            ovf_q <= 1'b1; // [RL6]
        end else if (ovf_clear_cmd) begin
            ovf_q <= 1'b0; // [RL7]
        end
    end

    // free running frame tallies
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_tally_q <= '0;
            rx_tally_q <= '0;
        end else begin
            if (tx_frame_tick) begin
                tx_tally_q <= TALLY_W'(tx_tally_q + 1'b1); // [RL17]
            end
            if (rx_frame_tick) begin
                rx_tally_q <= TALLY_W'(rx_tally_q + 1'b1); // [RL17]
            end
        end
    end

    // read of status clears it; new events win
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (ar_take && rd_irq_stat) begin
            irq_stat_d = '0;
        end
        irq_stat_d = irq_stat_d | irq_evt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // frame transfer sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_state_q <= DMA_IDLE;
            frame_idx_q <= '0;
            frame_ofs_q <= '0;
        end else begin
            case (dma_state_q)
                DMA_IDLE: begin
                    if (dma_en_q && frame_start) begin
                        dma_state_q <= DMA_REQ;
                    end
                end
                DMA_REQ: begin
                    if (dma_req_ready) begin
                        dma_state_q <= DMA_IDLE;
                        if (last_frame) begin
                            frame_idx_q <= '0; // [RL16]
                            frame_ofs_q <= '0;
                        end else begin
                            frame_idx_q <= CHANNEL_FRAMES_PER_BUFFER_W'(frame_idx_q + 1'b1);
                            frame_ofs_q <= frame_ofs_q + {{(DATA_W-STRIDE_W){1'b0}},
                                frame_stride}; // [RL14]
                        end
                    end
                end
                default: begin
                    dma_state_q <= DMA_IDLE;
                end
            endcase
        end
    end
endmodule

//--- testbench/tdm_chk.sv
`timescale 1ns/10ps
module tdm_chk
    import tdm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // frame transfers
    input wire logic dma_req_valid,
    input wire logic dma_req_ready,
    input wire logic [DATA_W-1:0] dma_req_addr,
    input wire logic [STRIDE_W-1:0] dma_req_bytes,
    input wire logic [CHANNEL_FRAMES_PER_BUFFER_W-1:0] dma_req_frame
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wait;
        dma_req_valid && !dma_req_ready;
    endsequence
    sequence s_done;
        dma_req_valid && dma_req_ready;
    endsequence
    a_base_aligned: assert property (dma_req_valid |-> dma_req_addr[1:0] == 2'h0)
        else $error("addr unaligned");
    a_length_aligned: assert property (dma_req_valid |-> dma_req_bytes[1:0] == 2'h0)
        else $error("length unaligned");
    a_frame_wraps: assert property (s_done |=> dma_req_frame == $past(dma_req_frame) + 8'h1
        || dma_req_frame == 8'h0)
        else $error("bad frame step");
    a_request_steady: assert property (s_wait |=> dma_req_valid && $stable(dma_req_addr)
        && $stable(dma_req_frame))
        else $error("request unstable");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data lost");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write response lost");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
endmodule
bind tdm_channel_status tdm_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dma_req_valid(dma_req_valid), .dma_req_ready(dma_req_ready),
    .dma_req_addr(dma_req_addr), .dma_req_bytes(dma_req_bytes),
    .dma_req_frame(dma_req_frame));

//--- testbench/mem_model.sv
`timescale 1ns/10ps
module mem_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // transfer handshake
    input wire logic req_valid,
    input wire logic slow,
    output logic ready
);
    logic [1:0] wait_q;
    logic ready_q;
    assign ready = ready_q;
    // raise ready one cycle after the request, or three cycles later still when slow
    always_ff @(posedge aclk) begin
        if (!aresetn || !req_valid || ready_q) begin
            wait_q <= 2'h0;
            ready_q <= 1'b0;
        end else if (wait_q == (slow ? 2'h3 : 2'h0)) begin
            ready_q <= 1'b1;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb import tdm_pkg::*; ;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, irq;
    logic arvalid, arready, rvalid, rready, cfg_a, cfg_b, tick, err_valid;
    logic frame_start, dma_valid, dma_ready, slow;
    logic [7:0] awaddr, araddr, code, live_id, buf_id, dma_frame;
    logic [31:0] wdata, rdata, dma_addr;
    logic [1:0] bresp, rresp, resp_seen;
    logic [11:0] dma_bytes;
    err_cat_t cat;
    int failures, num_checks, cycles;
    tdm_channel_status #(.DEPTH(4)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cfg_a_active(cfg_a), .cfg_b_active(cfg_b), .tx_frame_tick(tick), .rx_frame_tick(tick),
        .err_valid(err_valid), .err_category(cat), .fault_code(code), .err_on_rx(1'b0),
        .live_config_id(live_id), .buffer_config_id(buf_id), .frame_start(frame_start),
        .rx_frame_bytes(12'h000), .dma_req_valid(dma_valid), .dma_req_ready(dma_ready),
        .dma_req_addr(dma_addr), .dma_req_bytes(dma_bytes), .dma_req_frame(dma_frame),
        .irq(irq));
    mem_model mem (.aclk(aclk), .aresetn(aresetn), .req_valid(dma_valid), .slow(slow),
        .ready(dma_ready));
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        resp_seen = bresp;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        resp_seen = rresp;
        chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic ev(input err_cat_t c, input logic [7:0] k, input logic t);
        cat <= c;
        code <= k;
        err_valid <= !t;
        tick <= t;
        @(posedge aclk);
        {err_valid, tick} <= 2'b00;
        @(posedge aclk);
    endtask
    task automatic fr(input logic [31:0] e);
        frame_start <= 1'b1;
        @(posedge aclk);
        frame_start <= 1'b0;
        do @(posedge aclk); while (!(dma_valid && dma_ready));
        chk("dma addr", e, dma_addr);
        chk("dma bytes", 32'h8, 32'(dma_bytes));
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cfg_a, cfg_b, tick} = '0;
        {err_valid, frame_start, slow, awaddr, araddr, code, live_id, buf_id, wdata} = '0;
        cat = CAT_PLAIN;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            cfg_a <= (i == 1);
            cfg_b <= (i == 2);
            @(posedge aclk);
            rd(OFS_CFG_STATUS, i);
        end
        $display("config done");
        repeat (3) ev(CAT_PLAIN, 8'h00, 1'b1);
        live_id <= 8'h5a;
        buf_id <= 8'h3c;
        ev(CAT_PLAIN, 8'ha1, 1'b0);
        ev(CAT_FRAME, 8'hb2, 1'b0);
        ev(CAT_CONFIG, 8'hc3, 1'b0);
        rd(OFS_ERR_COUNT, 32'h3);
        rd(OFS_ERR_QUEUE, 32'ha100_0000);
        wr(OFS_ERR_CTRL, 32'h1);
        rd(OFS_ERR_QUEUE, 32'hb200_0003);
        wr(OFS_ERR_CTRL, 32'h1);
        rd(OFS_ERR_QUEUE, 32'hc300_5a3c);
        rd(OFS_ERR_CTRL, 32'h0);
        rd(OFS_TX_TALLY, 32'h3);
        rd(OFS_RX_TALLY, 32'h3);
        wr(OFS_ERR_CTRL, 32'h2);
        rd(OFS_ERR_COUNT, 32'h0);
        wr(OFS_ERR_CTRL, 32'h1);
        rd(OFS_ERR_COUNT, 32'h0);
        $display("entries done");
        for (int i = 0; i < 5; i++) ev(CAT_PLAIN, 8'(i), 1'b0);
        rd(OFS_ERR_COUNT, 32'h104);
        wr(OFS_ERR_CTRL, 32'h1);
        rd(OFS_ERR_COUNT, 32'h103);
        wr(OFS_ERR_CTRL, 32'h0);
        rd(OFS_ERR_COUNT, 32'h103);
        wr(OFS_ERR_CTRL, 32'h100);
        rd(OFS_ERR_COUNT, 32'h3);
        $display("overflow done");
        wr(OFS_BUF_BASE, 32'h1003);
        rd(OFS_BUF_BASE, 32'h1000);
        wr(OFS_FRAME_STRIDE, 32'h107);
        rd(OFS_FRAME_STRIDE, 32'h104);
        wr(OFS_FRAME_LENGTH, 32'hb);
        rd(OFS_FRAME_LENGTH, 32'h8);
        wr(OFS_FRAMES_PER_BUF, 32'h2);
        wr(OFS_DMA_CTRL, 32'h1);
        fr(32'h1000);
        slow <= 1'b1;
        fr(32'h1104);
        fr(32'h1000);
        wr(8'hfc, 32'h0);
        chk("bresp", 32'(RESP_DECERR), 32'(resp_seen));
        rd(8'hfc, 32'h0);
        chk("rresp", 32'(RESP_DECERR), 32'(resp_seen));
        $display("buffer done");
        chk("irq masked", 32'h0, 32'(irq));
        rd(OFS_IRQ_STATUS, 32'h7);
        wr(OFS_IRQ_MASK, 32'h1);
        ev(CAT_PLAIN, 8'h11, 1'b0);
        chk("irq", 32'h1, 32'(irq));
        rd(OFS_IRQ_STATUS, 32'h1);
        @(posedge aclk);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("irq done");
        finish_test();
    end
endmodule
